// ### hw/cabx_core.sv
// executes the add, jump and call instructions of the nibble cpu
`timescale 1ns/1ps
module cabx_core
    import cabx_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // program memory
    output logic      [PC_W-1:0]   prog_addr,
    input  wire logic [WORD_W-1:0] prog_word,
    // data ram
    output logic      [MP_W-1:0]   ram_addr,
    input  wire logic [NIB_W-1:0]  ram_rdata,
    // converter
    output logic                   conv_start,
    output logic                   conv_compare_mode,
    input  wire logic              conv_done
);
    // =====================================================================
    // state
    typedef enum logic {ST_ONE, ST_TWO} cabx_state_t;

    cabx_state_t       state_q, state_d;
    logic              run_q, skip_q, skip_d, carry_flag_q, carry_flag_d;
    logic              conversion_done_flag_q, conv_start_q;
    logic [NIB_W-1:0]  acc_q, acc_d, converter_control_reg_q;
    logic [PC_W-1:0]   pc_q, pc_d, pc_inc, stack_top;
    logic [WORD_W-1:0] hold_q;
    logic [MP_W-1:0]   memory_pointer_q;
    logic [IDX_W-1:0]  index_register_low_bits_q;
    logic [SP_W-1:0]   stack_index;
    logic [31:0]       prdata_q, rd_mux;

    // refused at elaboration: the index width fixes the depth
    if (DEPTH != STACK_DEPTH)
    begin : g_depth_check
        $error("return stack depth is fixed by the index width");
    end

    // =====================================================================
    // decode
    wire [WORD_W-1:0] w          = prog_word;
    wire dec_addi   = w[9:4] == OP_SUM_IMM_HI;
    wire dec_launch = w == OP_LAUNCH;
    wire dec_am     = w == OP_SUM_MEM;
    wire dec_amc    = w == OP_SUM_MEM_CY;
    wire dec_and    = w == OP_AND_MEM;
    wire dec_jmp    = w[9:7] == OP_JUMP_PAGE_HI;
    wire dec_call2  = w[9:7] == OP_CALL_TWO_HI;
    wire dec_bl     = w[9:5] == OP_LONG_JUMP_HI;
    wire dec_bml    = w[9:5] == OP_LONG_CALL_HI;
    wire dec_bla    = w == OP_JUMP_IND;
    wire is_two     = dec_bl | dec_bml | dec_bla;
    wire hold_bl    = hold_q[9:5] == OP_LONG_JUMP_HI;
    wire hold_bml   = hold_q[9:5] == OP_LONG_CALL_HI;
    wire hold_bla   = hold_q == OP_JUMP_IND;

    wire one        = run_q & (state_q == ST_ONE);
    wire two        = run_q & (state_q == ST_TWO);
    wire live1      = one & ~skip_q;
    wire ex_addi    = live1 & dec_addi;
    wire ex_launch  = live1 & dec_launch;
    wire ex_am      = live1 & dec_am;
    wire ex_amc     = live1 & dec_amc;
    wire ex_and     = live1 & dec_and;
    wire ex_jmp     = live1 & dec_jmp;
    wire ex_call2   = live1 & dec_call2;
    wire ex2        = two & ~skip_q;
    wire ex_bl2     = ex2 & hold_bl;
    wire ex_bml2    = ex2 & hold_bml;
    wire ex_bla2    = ex2 & hold_bla;
    // a skipped two-word instruction is dropped as a whole, both words
    wire kill       = (one & skip_q & ~is_two) | (two & skip_q);
    wire push       = ex_call2 | ex_bml2;

    // =====================================================================
    // arithmetic
    logic [NIB_W-1:0] alu_res;
    logic             alu_cout;

    cabx_alu u_alu (
        .a       (acc_q),
        .b       (dec_addi ? w[NIB_W-1:0] : ram_rdata),
        .cin     (dec_amc & carry_flag_q),
        .use_and (dec_and),
        .res     (alu_res),
        .cout    (alu_cout)
    );

    cabx_stack #(.DEPTH(DEPTH), .AW(SP_W)) u_stack (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (push),
        .push_addr (pc_inc),
        .index     (stack_index),
        .top       (stack_top)
    );

    // =====================================================================
    // apb decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = a == r;
    endfunction

    wire setup  = psel & ~penable;
    wire access = psel & penable;
    wire wr     = access & pwrite;
    wire mapped = hit(paddr, REG_CTRL) | hit(paddr, REG_ACC) | hit(paddr, REG_PC)
                | hit(paddr, REG_STACK) | hit(paddr, REG_CONV) | hit(paddr, REG_PTR);
    wire wr_ctrl = wr & hit(paddr, REG_CTRL);
    // accumulator and counter accept software only while halted
    wire wr_acc  = wr & hit(paddr, REG_ACC) & ~run_q;
    wire wr_pc   = wr & hit(paddr, REG_PC) & ~run_q;
    wire wr_conv = wr & hit(paddr, REG_CONV);
    wire wr_ptr  = wr & hit(paddr, REG_PTR);

    assign rd_mux = hit(paddr, REG_CTRL)  ? {31'h0, run_q}
                  : hit(paddr, REG_ACC)   ? {27'h0, carry_flag_q, acc_q}
                  : hit(paddr, REG_PC)    ? {19'h0, skip_q, pc_q}
                  : hit(paddr, REG_STACK) ? {17'h0, stack_top, stack_index}
                  : hit(paddr, REG_CONV)  ? {27'h0, conversion_done_flag_q,
                                             converter_control_reg_q}
                  : hit(paddr, REG_PTR)   ? {21'h0, index_register_low_bits_q,
                                             memory_pointer_q}
                  : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    // =====================================================================
    // next state
    // the low part carries into the page, so code runs on past a page end
    assign pc_inc = pc_q + 1'b1;
    assign pc_d   = wr_pc     ? pwdata[PC_W-1:0]
                  : ex_jmp    ? {pc_q[PC_W-1:LOW_W], w[LOW_W-1:0]}
                  : ex_call2  ? {CALL_PAGE, w[LOW_W-1:0]}
                  : (ex_bl2 | ex_bml2) ? {hold_q[PAGE_W-1:0], w[LOW_W-1:0]}
                  : ex_bla2   ? {w[IND_PAGE_TOP_BIT], w[3:0], index_register_low_bits_q,
                                 acc_q}
                  : run_q     ? pc_inc
                  : pc_q;
    assign acc_d  = wr_acc ? pwdata[NIB_W-1:0]
                  : (ex_addi | ex_am | ex_amc | ex_and) ? alu_res
                  : acc_q;
    assign carry_flag_d = wr_acc ? pwdata[ACC_CARRY_BIT]
                        : ex_amc ? alu_cout
                        : carry_flag_q;
    assign skip_d  = ex_addi ? ~alu_cout
                   : (kill | wr_pc) ? 1'b0
                   : skip_q;
    assign state_d = (one & is_two) ? ST_TWO
                   : two ? ST_ONE
                   : state_q;

    assign prog_addr         = pc_q;
    assign ram_addr          = memory_pointer_q;
    assign conv_start        = conv_start_q;
    assign conv_compare_mode = converter_control_reg_q[CMP_MODE_BIT];

    // =====================================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q      <= ST_ONE;
            run_q        <= 1'b0;
            pc_q         <= PC_RST;
            acc_q        <= ACC_RST;
            carry_flag_q <= 1'b0;
            skip_q       <= 1'b0;
            hold_q       <= '0;
        end
        else
        begin
            state_q      <= state_d;
            run_q        <= wr_ctrl ? pwdata[CTRL_RUN_BIT] : run_q;
            pc_q         <= pc_d;
            acc_q        <= acc_d;
            carry_flag_q <= carry_flag_d;
            skip_q       <= skip_d;
            hold_q       <= one ? w : hold_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_control_reg_q   <= CONV_RST;
            conversion_done_flag_q    <= 1'b0;
            conv_start_q              <= 1'b0;
            memory_pointer_q          <= MP_RST;
            index_register_low_bits_q <= IDX_RST;
            prdata_q                  <= 32'h0;
        end
        else
        begin
            if (wr_conv)
                converter_control_reg_q <= pwdata[NIB_W-1:0];
            // a finishing conversion beats a clear in the same cycle
            conversion_done_flag_q <= conv_done | (conversion_done_flag_q & ~ex_launch);
            conv_start_q <= ex_launch;
            if (wr_ptr)
            begin
                memory_pointer_q          <= pwdata[MP_W-1:0];
                index_register_low_bits_q <= pwdata[PTR_IDX_LSB +: IDX_W];
            end
            prdata_q <= setup ? rd_mux : prdata_q;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_bl_pair;
        (live1 & dec_bl) ##1 ex_bl2;
    endsequence
    sequence s_bml_pair;
        (live1 & dec_bml) ##1 ex_bml2;
    endsequence

    property p_addi_sum;
        ex_addi |=> acc_q == 4'($past(acc_q) + $past(prog_word[3:0]));
    endproperty
    a_addi_sum: assert property (p_addi_sum) else $error("immediate sum wrong");
    property p_addi_carry;
        ex_addi & ~wr_acc |=> carry_flag_q == $past(carry_flag_q);
    endproperty
    a_addi_carry: assert property (p_addi_carry) else $error("carry moved");
    property p_addi_skip;
        ex_addi ##1 run_q & ~wr_pc & (state_q == ST_ONE) & ~is_two
            |-> skip_q == ({1'b0, $past(acc_q)} + {1'b0, $past(prog_word[3:0])} < 5'h10)
                ##1 (~$past(skip_q) || ~skip_q);
    endproperty
    a_addi_skip: assert property (p_addi_skip) else $error("skip wrong");
    property p_launch;
        ex_launch & ~conv_done |=> conv_start & ~conversion_done_flag_q;
    endproperty
    a_launch: assert property (p_launch) else $error("launch failed");
    property p_am;
        ex_am & ~wr_acc |=> acc_q == 4'($past(acc_q) + $past(ram_rdata))
            && carry_flag_q == $past(carry_flag_q);
    endproperty
    a_am: assert property (p_am) else $error("memory sum wrong");
    property p_amc;
        ex_amc & ~wr_acc |=> {carry_flag_q, acc_q} == 5'({1'b0, $past(acc_q)}
            + {1'b0, $past(ram_rdata)} + {4'h0, $past(carry_flag_q)});
    endproperty
    a_amc: assert property (p_amc) else $error("carry sum wrong");
    property p_and;
        ex_and & ~wr_acc |=> acc_q == ($past(acc_q) & $past(ram_rdata));
    endproperty
    a_and: assert property (p_and) else $error("and wrong");
    property p_jmp;
        ex_jmp & ~wr_pc |=> pc_q == {$past(pc_q[PC_W-1:LOW_W]), $past(prog_word[LOW_W-1:0])};
    endproperty
    a_jmp: assert property (p_jmp) else $error("in-page jump wrong");
    property p_bl;
        s_bl_pair |=> pc_q == {$past(hold_q[PAGE_W-1:0]), $past(prog_word[LOW_W-1:0])};
    endproperty
    a_bl: assert property (p_bl) else $error("long jump wrong");
    property p_call2;
        ex_call2 & ~wr_pc |=> pc_q[PC_W-1:LOW_W] == CALL_PAGE
            && stack_index == 3'($past(stack_index) + 1) && stack_top == $past(pc_inc);
    endproperty
    a_call2: assert property (p_call2) else $error("page-two call wrong");
    property p_bml;
        s_bml_pair |=> stack_index == 3'($past(stack_index, 2) + 1)
            && pc_q == {$past(hold_q[PAGE_W-1:0]), $past(prog_word[LOW_W-1:0])};
    endproperty
    a_bml: assert property (p_bml) else $error("long call wrong");
    property p_kill;
        kill & ~wr_pc & ~wr_acc |=> pc_q == 12'($past(pc_q) + 1) && acc_q == $past(acc_q);
    endproperty
    a_kill: assert property (p_kill) else $error("skipped word acted");
    property p_one_cycle;
        (ex_addi | ex_am | ex_and | ex_launch | ex_jmp) & run_q |=> state_q == ST_ONE;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("single word took two");
endmodule // cabx_core

// ### hw/cabx_pkg.sv
// shared constants for the add, branch and call execution block
package cabx_pkg;
    // =====================================================================
    // widths
    localparam int PAGE_W      = 5;
    localparam int LOW_W       = 7;
    localparam int PC_W        = 12;
    localparam int NIB_W       = 4;
    localparam int WORD_W      = 10;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;
    localparam int MP_W        = 8;
    localparam int IDX_W       = 3;
    localparam int ADDR_W      = 8;

    // =====================================================================
    // instruction encodings
    localparam logic [5:0]  OP_SUM_IMM_HI   = 6'h06;
    localparam logic [9:0]  OP_LAUNCH       = 10'h29f;
    localparam logic [9:0]  OP_SUM_MEM      = 10'h00a;
    localparam logic [9:0]  OP_SUM_MEM_CY   = 10'h00b;
    localparam logic [9:0]  OP_AND_MEM      = 10'h018;
    localparam logic [2:0]  OP_JUMP_PAGE_HI = 3'h3;
    localparam logic [2:0]  OP_CALL_TWO_HI  = 3'h2;
    localparam logic [4:0]  OP_LONG_JUMP_HI = 5'h07;
    localparam logic [4:0]  OP_LONG_CALL_HI = 5'h06;
    localparam logic [9:0]  OP_JUMP_IND     = 10'h010;
    localparam logic [PAGE_W-1:0] CALL_PAGE = 5'h02;
    localparam int IND_PAGE_TOP_BIT         = 6;

    // =====================================================================
    // register map and fields
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ACC    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PC     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STACK  = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CONV   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_PTR    = 8'h14;
    localparam int CTRL_RUN_BIT              = 0;
    localparam int ACC_CARRY_BIT             = 4;
    localparam int CONV_DONE_BIT             = 4;
    localparam int CMP_MODE_BIT              = 3;
    localparam int PTR_IDX_LSB               = 8;

    // =====================================================================
    // reset values
    localparam logic [NIB_W-1:0] ACC_RST     = 4'h0;
    localparam logic [PC_W-1:0]  PC_RST      = 12'h000;
    localparam logic [NIB_W-1:0] CONV_RST    = 4'h0;
    localparam logic [MP_W-1:0]  MP_RST      = 8'h00;
    localparam logic [IDX_W-1:0] IDX_RST     = 3'h0;
endpackage

// ### hw/cabx_alu.sv
// nibble adder with carry and bitwise conjunction
`timescale 1ns/1ps
module cabx_alu
    import cabx_pkg::*;
(
    // operands
    input  wire logic [NIB_W-1:0] a,
    input  wire logic [NIB_W-1:0] b,
    input  wire logic             cin,
    input  wire logic             use_and,
    // result
    output logic      [NIB_W-1:0] res,
    output logic                  cout
);
    // =====================================================================
    // datapath
    logic [NIB_W:0] sum;

    assign sum  = {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, cin};
    assign res  = use_and ? (a & b) : sum[NIB_W-1:0];
    assign cout = use_and ? 1'b0 : sum[NIB_W];
endmodule // cabx_alu

// ### hw/cabx_stack.sv
// return stack with its index
`timescale 1ns/1ps
module cabx_stack
    import cabx_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW    = SP_W
)(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // push side
    input  wire logic          push,
    input  wire logic [PC_W-1:0] push_addr,
    // state
    output logic      [AW-1:0]   index,
    output logic      [PC_W-1:0] top
);
    // =====================================================================
    // storage
    logic [PC_W-1:0] return_stack [DEPTH];
    logic [AW-1:0]   stack_index_q;
    logic [AW-1:0]   stack_index_d;

    // refused at elaboration: the index must wrap exactly at the depth
    if (DEPTH != (1 << AW))
    begin : g_depth_check
        $error("stack depth must equal two to the index width");
    end

    // deeper nesting than the depth wraps and overwrites the oldest entry
    assign stack_index_d = push ? stack_index_q + 1'b1 : stack_index_q;
    assign index         = stack_index_q;
    assign top           = return_stack[stack_index_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_index_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                return_stack[i] <= '0;
        end
        else
        begin
            stack_index_q <= stack_index_d;
            if (push)
                return_stack[stack_index_d] <= push_addr;
        end
    end
endmodule // cabx_stack

// ### testbench/cabx_far_model.sv
// far-side model: program rom, data ram and a slow converter
`timescale 1ns/1ps
module cabx_far_model
    import cabx_pkg::*;
#(
    parameter int CONV_LAT = 30
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // program memory
    input  wire logic [PC_W-1:0]   prog_addr,
    output logic      [WORD_W-1:0] prog_word,
    // data ram
    input  wire logic [MP_W-1:0]   ram_addr,
    output logic      [NIB_W-1:0]  ram_rdata,
    // converter
    input  wire logic              conv_start,
    output logic                   conv_done
);
    // ==========
    // memories, loaded by the bench
    logic [WORD_W-1:0] rom [0:(1<<PC_W)-1];
    logic [NIB_W-1:0]  ram [0:(1<<MP_W)-1];
    int                busy_q;

    assign prog_word = rom[prog_addr];
    assign ram_rdata = ram[ram_addr];

    // ==========
    // converter
    // done comes long after the launch so that a fresh clear is visible
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q    <= 0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= (busy_q == 1);
            if (conv_start)
                busy_q <= CONV_LAT;
            else if (busy_q != 0)
                busy_q <= busy_q - 1;
        end
    end
endmodule // cabx_far_model

// ### testbench/testbench.sv
// self-checking bench for the add, jump and call execution block
`timescale 1ns/1ps
module testbench
    import cabx_pkg::*;
;
    // ==========
    // signals
    typedef struct packed {
        logic [11:0] pc0;
        logic [9:0]  w0, w1, w2;
        logic [11:0] lp;
        logic [4:0]  acc0;
        logic [3:0]  ram;
        logic [2:0]  idx;
        logic [4:0]  eacc;
        logic [14:0] estk;
    } cabx_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, smode;
    logic [7:0]  paddr, ram_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] prog_addr;
    logic [9:0]  prog_word;
    logic [3:0]  ram_rdata;
    logic        conv_start, conv_compare_mode, conv_done;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          starts = 0;
    // pc0 words loop acc ram idx -> acc stack; nesting stays at two calls
    localparam cabx_row_t ROWS [12] = '{
        '{12'h000, 10'h065, 10'h018, 10'h182, 12'h002, 5'h13, 4'h0, 3'h0, 5'h18, 15'h0000},
        '{12'h010, 10'h065, 10'h018, 10'h192, 12'h012, 5'h0c, 4'h2, 3'h0, 5'h00, 15'h0000},
        '{12'h020, 10'h06f, 10'h00a, 10'h1a2, 12'h022, 5'h10, 4'h1, 3'h0, 5'h1f, 15'h0000},
        '{12'h030, 10'h00a, 10'h1b1, 10'h000, 12'h031, 5'h19, 4'h8, 3'h0, 5'h11, 15'h0000},
        '{12'h040, 10'h00b, 10'h1c1, 10'h000, 12'h041, 5'h19, 4'h8, 3'h0, 5'h12, 15'h0000},
        '{12'h048, 10'h00b, 10'h1c9, 10'h000, 12'h049, 5'h13, 4'h2, 3'h0, 5'h06, 15'h0000},
        '{12'h050, 10'h018, 10'h1d1, 10'h000, 12'h051, 5'h1e, 4'h7, 3'h0, 5'h16, 15'h0000},
        '{12'h17e, 10'h185, 10'h000, 10'h000, 12'h105, 5'h05, 4'h0, 3'h0, 5'h05, 15'h0000},
        '{12'h060, 10'h17f, 10'h000, 10'h000, 12'h180, 5'h05, 4'h0, 3'h0, 5'h05, 15'h0309},
        '{12'h070, 10'h0ff, 10'h233, 10'h000, 12'hfb3, 5'h05, 4'h0, 3'h0, 5'h05, 15'h0309},
        '{12'h078, 10'h010, 10'h243, 10'h000, 12'h9d9, 5'h09, 4'h0, 3'h5, 5'h09, 15'h0309},
        '{12'h088, 10'h0c4, 10'h210, 10'h000, 12'h210, 5'h09, 4'h0, 3'h0, 5'h09, 15'h0452}};

    // ==========
    // design and far side
    cabx_core #(.DEPTH(STACK_DEPTH)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_word(prog_word),
        .ram_addr(ram_addr), .ram_rdata(ram_rdata), .conv_start(conv_start),
        .conv_compare_mode(conv_compare_mode), .conv_done(conv_done));
    cabx_far_model #(.CONV_LAT(30)) far (
        .pclk(pclk), .presetn(presetn), .prog_addr(prog_addr), .prog_word(prog_word),
        .ram_addr(ram_addr), .ram_rdata(ram_rdata), .conv_start(conv_start),
        .conv_done(conv_done));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ==========
    // tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // runs until the counter sits on its self loop, then halts
    task automatic run_to(input logic [11:0] lp);
        int n;
        apb(1'b1, REG_CTRL, 32'h1);
        n = 0;
        while (prog_addr !== lp && n < 30)
        begin
            @(posedge pclk);
            n++;
        end
        apb(1'b1, REG_CTRL, 32'h0);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // timeout and launch monitor
    always @(posedge pclk)
    begin
        cycles++;
        if (conv_start === 1'b1)
        begin
            starts++;
            smode = conv_compare_mode;
        end
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========
    // main sequence
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 6; a++)
        begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", rd & ((a == 3) ? 32'h7 : 32'hffffffff), 32'h0);
        end
        $display("test reset done");
        foreach (ROWS[i])
        begin
            for (int k = 0; k < 4096; k++)
                far.rom[k] = 10'h000;
            far.rom[ROWS[i].pc0] = ROWS[i].w0;
            far.rom[ROWS[i].pc0 + 12'h001] = ROWS[i].w1;
            far.rom[ROWS[i].pc0 + 12'h002] = ROWS[i].w2;
            far.rom[ROWS[i].lp] = {3'h3, ROWS[i].lp[6:0]};
            far.ram[8'h05] = ROWS[i].ram;
            apb(1'b1, REG_PTR, {21'h0, ROWS[i].idx, 8'h05});
            apb(1'b1, REG_ACC, {27'h0, ROWS[i].acc0});
            apb(1'b1, REG_PC, {20'h0, ROWS[i].pc0});
            run_to(ROWS[i].lp);
            apb(1'b0, REG_ACC, 32'h0);
            chk("acc", rd, {27'h0, ROWS[i].eacc});
            apb(1'b0, REG_PC, 32'h0);
            chk("pc", rd, {20'h0, ROWS[i].lp});
            apb(1'b0, REG_STACK, 32'h0);
            chk("stack", rd, {17'h0, ROWS[i].estk});
            $display("test row %0d done", i);
        end
        // second launch must clear the done flag left by the first
        for (int m = 0; m < 2; m++)
        begin
            far.rom[12'h090] = OP_LAUNCH;
            far.rom[12'h091] = 10'h191;
            apb(1'b1, REG_CONV, {28'h0, 1'(m), 3'h0});
            apb(1'b1, REG_PC, 32'h090);
            run_to(12'h091);
            chk("mode level", conv_compare_mode, 32'(m));
            apb(1'b0, REG_CONV, 32'h0);
            chk("conv reg", rd, {28'h0, 1'(m), 3'h0});
            chk("starts", starts, 32'(m + 1));
            chk("start mode", smode, 32'(m));
            repeat (40) @(posedge pclk);
            apb(1'b0, REG_CONV, 32'h0);
            chk("done", rd[4], 1'b1);
            $display("test launch %0d done", m);
        end
        far.rom[12'h0a0] = 10'h1a0;
        apb(1'b1, REG_PC, 32'h0a0);
        apb(1'b1, REG_ACC, 32'h5);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b1, REG_ACC, 32'ha);
        apb(1'b1, REG_STACK, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_ACC, 32'h0);
        chk("acc held", rd, 32'h5);
        apb(1'b0, REG_STACK, 32'h0);
        chk("stack read only", rd[14:0], 15'h0452);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        $display("test access done");
        // reset in mid-run while the core spins on its loop
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset pc", prog_addr, 32'h0);
        chk("reset mode", conv_compare_mode, 32'h0);
        chk("reset start", conv_start, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, REG_STACK, 32'h0);
        chk("reset stack", rd, 32'h0);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("reset run", rd, 32'h0);
        apb(1'b0, REG_CONV, 32'h0);
        chk("reset conv", rd, 32'h0);
        $display("test mid reset done");
        print_verdict();
    end
endmodule // testbench
